// ==== acw_pkg.sv ====
// constants for the amplifier control word and drive mode block
package acw_pkg;
  localparam int unsigned SYS_CLK_HZ     = 20000000;
  localparam int unsigned WORD_BITS      = 72;
  localparam int unsigned PRE_BITS       = 8;
  localparam int unsigned REG_BITS       = 64;
  localparam int unsigned CNT_W          = 7;
  localparam logic [6:0]  CNT_LAST       = 7'h47;
  localparam logic [6:0]  CNT_DIR_BIT    = 7'h07;
  // reference code value is arbitrary, chosen only to mark our own preamble
  localparam logic [3:0]  SILICON_REF    = 4'h6;
  localparam logic [1:0]  DIR_READ       = 2'h3;
  localparam logic [1:0]  DIR_WRITE      = 2'h2;
  localparam logic [1:0]  CHIP_ADDR      = 2'h0;
  localparam int unsigned LEFT_LSB       = 0;
  localparam int unsigned RIGHT_LSB      = 9;
  localparam int unsigned VOL_W          = 9;
  localparam int unsigned LOW_DIR_BIT    = 18;
  localparam int unsigned LOW_GAIN_LSB   = 19;
  localparam int unsigned LOW_CORNER_LSB = 23;
  localparam int unsigned HIGH_DIR_BIT   = 25;
  localparam int unsigned HIGH_GAIN_LSB  = 26;
  localparam int unsigned HIGH_CORNER_LSB = 30;
  localparam logic [8:0]  VOL_RESET      = 9'h0FA;
  localparam logic [63:0] REG_RESET      = {28'h0000000, 18'h0, VOL_RESET, VOL_RESET};
  localparam int unsigned MUTE_HOLD_MS   = 500;
  localparam int unsigned MUTE_HOLD_CYC  = MUTE_HOLD_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned DEAD_CYC       = 1;
  typedef enum logic [1:0] {
    ACW_IDLE  = 2'b00,
    ACW_SHIFT = 2'b01,
    ACW_READ  = 2'b10,
    ACW_BAD   = 2'b11
  } acw_link_t;
endpackage

// ==== acw_gate_pair.sv ====
// one n/p gate-drive pair with optional dead time
`timescale 1ns/100ps
module acw_gate_pair (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic level,
  input  wire logic enable,
  input  wire logic dead_en,
  output logic      gate_n,
  output logic      gate_p
);
  logic level_r;
  logic gap_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= 1'b0;
      gap_r   <= 1'b0;
    end else begin
      level_r <= level;
      gap_r   <= dead_en && (level != level_r); // R6
    end
  end

  // gate_n on for high level, gate_p for low; both off while disabled or in gap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_n <= 1'b0;
      gate_p <= 1'b0;
    end else if (!enable) begin
      gate_n <= 1'b0; // R1
      gate_p <= 1'b0;
    end else if (dead_en && ((level != level_r) || gap_r)) begin
      gate_n <= 1'b0; // R6 R7
      gate_p <= 1'b0;
    end else begin
      gate_n <= level; // R5
      gate_p <= !level;
    end
  end

  a_gap_both_off : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(gate_n && gate_p)) else $error("both gates on"); // R6
endmodule

// ==== acw_core.sv ====
// serial control word, control register fields and gated pwm drive
`timescale 1ns/100ps
// What this block does
// [R1] mute pin low forces every gate output off.
// [R2] after mute release outputs stay off about half a second.
// [R3] eight gate outputs, four per channel, two n/p pairs each.
// [R4] select pins 00 gives no dead time, 10 gives dead time.
// [R5] without dead time both gates of a pair switch together.
// [R6] with dead time the active gate turns off before the other turns on.
// [R7] the gap is derived from the clock, about half a master period; here it is fixed at two system cycles.
// [R8] each word is 72 bits: 8 preamble then 64 data.
// [R9] host drives both chip address bits low.
// [R10] preamble carries silicon reference then two direction bits.
// [R11] enable low for exactly 72 clocks or the word is dropped.
// [R12] on read, data pin turns to output after direction bit.
// [R13] host keeps enable high three master clocks between words.
// [R14] 64-bit register resets to zero except stated fields.
// [R15] data goes most significant bit first, bit zero last.
// [R16] volume codes: left bits 0-8, right bits 9-17.
// [R17] both volumes reset to code 011111010, minus 2 dB.
// [R18] bit 18 selects bass boost (1) or cut (0).
// [R19] bits 19-22 give bass gain magnitude.
// [R20] bits 23-24 select the bass corner.
// [R21] bit 25 selects treble boost (1) or cut (0).
// [R22] bits 26-29 give treble gain magnitude.
// [R23] bits 30-31 select the treble corner.
// [R24] corner code 11 is stored and read back, not used.
module acw_core #(
  parameter int unsigned MUTE_HOLD = acw_pkg::MUTE_HOLD_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        master_clock_pin,
  input  wire logic        serial_enable_n,
  input  wire logic        serial_clock_line,
  input  wire logic        serial_data_line_i,
  output logic             serial_data_line_o,
  output logic             serial_data_line_oe_n,
  input  wire logic        mute_n,
  input  wire logic        drive_select_a,
  input  wire logic        drive_select_b,
  input  wire logic [1:0]  pwm_left,
  input  wire logic [1:0]  pwm_right,
  output logic [3:0]       gate_left,
  output logic [3:0]       gate_right,
  output logic [8:0]       left_gain_code,
  output logic [8:0]       right_gain_code,
  output logic             low_tone_direction,
  output logic [3:0]       low_tone_gain,
  output logic [1:0]       low_tone_corner,
  output logic             high_tone_direction,
  output logic [3:0]       high_tone_gain,
  output logic [1:0]       high_tone_corner,
  output logic             low_corner_valid,
  output logic             high_corner_valid,
  output logic             dead_time_on,
  output logic             drive_enabled
);
  logic        rst_a_r;
  logic        rst_n;
  logic [1:0]  sync_ck_r;
  logic [1:0]  sync_en_r;
  logic [1:0]  sync_da_r;
  logic [1:0]  sync_mute_r;
  logic [1:0]  sync_sa_r;
  logic [1:0]  sync_sb_r;
  logic        ck_d_r;
  logic        ck_rise;
  logic        ck_fall;
  logic        en_n;
  logic [63:0] ctrl_r;
  logic [63:0] shift_r;
  logic [7:0]  pre_r;
  logic [6:0]  cnt_r;
  logic [63:0] read_r;
  logic        out_en_r;
  logic        dout_r;
  acw_pkg::acw_link_t st_r;
  logic [31:0] hold_r;
  logic        drive_r;
  logic        dead_r;
  logic        master_unused;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end

  // serial, mute and select pins cross two flops before use; pwm inputs go straight to the gate pairs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_ck_r   <= 2'h0;
      sync_en_r   <= 2'h3;
      sync_da_r   <= 2'h0;
      sync_mute_r <= 2'h0;
      sync_sa_r   <= 2'h0;
      sync_sb_r   <= 2'h0;
      ck_d_r      <= 1'b0;
    end else begin
      sync_ck_r   <= {sync_ck_r[0], serial_clock_line};
      sync_en_r   <= {sync_en_r[0], serial_enable_n};
      sync_da_r   <= {sync_da_r[0], serial_data_line_i};
      sync_mute_r <= {sync_mute_r[0], mute_n};
      sync_sa_r   <= {sync_sa_r[0], drive_select_a};
      sync_sb_r   <= {sync_sb_r[0], drive_select_b};
      ck_d_r      <= sync_ck_r[1];
    end
  end

  assign ck_rise = sync_ck_r[1] && !ck_d_r;
  assign ck_fall = !sync_ck_r[1] && ck_d_r;
  assign en_n    = sync_en_r[1];
  // master clock only sets the gap length; the gap is two system cycles here
  assign master_unused = master_clock_pin;

  // serial word receiver: counts bits while enable is low
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= acw_pkg::ACW_IDLE;
      cnt_r   <= 7'h00;
      pre_r   <= 8'h00;
      shift_r <= 64'h0;
    end else begin
      case (st_r)
        acw_pkg::ACW_IDLE: begin
          cnt_r <= 7'h00;
          if (!en_n) begin
            st_r <= acw_pkg::ACW_SHIFT;
          end
        end
        acw_pkg::ACW_SHIFT, acw_pkg::ACW_READ: begin
          if (en_n) begin
            st_r <= acw_pkg::ACW_IDLE; // R11
          end else if (ck_rise) begin
            if (cnt_r < 7'(acw_pkg::PRE_BITS)) begin
              pre_r <= {pre_r[6:0], sync_da_r[1]}; // R8
            end else begin
              shift_r <= {shift_r[62:0], sync_da_r[1]}; // R15
            end
            // a 73rd rising clock makes the word too long
            if (cnt_r == 7'(acw_pkg::WORD_BITS)) begin
              st_r <= acw_pkg::ACW_BAD; // R11
            end
            cnt_r <= cnt_r + 7'h01;
            if (cnt_r == acw_pkg::CNT_DIR_BIT &&
                {pre_r[6:0], sync_da_r[1]} == {acw_pkg::CHIP_ADDR, acw_pkg::SILICON_REF,
                                               acw_pkg::DIR_READ}) begin
              st_r <= acw_pkg::ACW_READ; // R10
            end
          end
        end
        acw_pkg::ACW_BAD: begin
          if (en_n) begin
            st_r <= acw_pkg::ACW_IDLE;
          end
        end
        default: st_r <= acw_pkg::ACW_IDLE;
      endcase
    end
  end

  // commit only a complete 72-bit write word with valid preamble
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= acw_pkg::REG_RESET; // R14 R17
    end else if (en_n && st_r == acw_pkg::ACW_SHIFT && cnt_r == 7'(acw_pkg::WORD_BITS) &&
                 pre_r == {acw_pkg::CHIP_ADDR, acw_pkg::SILICON_REF,
                           acw_pkg::DIR_WRITE}) begin
      ctrl_r <= shift_r; // R11 R9 R10 R24
    end
  end

  // read-back: pin turns to output on falling edge after direction bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_r <= 1'b0;
      dout_r   <= 1'b0;
      read_r   <= 64'h0;
    end else if (st_r != acw_pkg::ACW_READ || en_n) begin
      out_en_r <= 1'b0;
      read_r   <= ctrl_r;
    end else if (ck_fall) begin
      out_en_r <= 1'b1; // R12
      dout_r   <= read_r[63]; // R15
      read_r   <= {read_r[62:0], 1'b0};
    end
  end

  assign serial_data_line_o    = dout_r;
  assign serial_data_line_oe_n = !out_en_r;

  // mute and the post-release hold; a long counter traded for simple logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r  <= 32'h0;
      drive_r <= 1'b0;
    end else if (!sync_mute_r[1]) begin
      hold_r  <= 32'h0; // R1
      drive_r <= 1'b0;
    end else if (hold_r < MUTE_HOLD) begin
      hold_r  <= hold_r + 32'h1; // R2
      drive_r <= 1'b0;
    end else begin
      drive_r <= 1'b1;
    end
  end

  // 10 selects dead time; 00 and undefined codes run without
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dead_r <= 1'b0;
    end else begin
      dead_r <= sync_sa_r[1] && !sync_sb_r[1]; // R4
    end
  end

  // two pairs per channel: a/b and c/d
  for (genvar g = 0; g < 4; g++) begin : g_pair // R3
    logic lvl;
    logic [1:0] pair;
    assign lvl = (g < 2) ? pwm_left[g % 2] : pwm_right[g % 2];
    acw_gate_pair u_pair (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .level   (lvl),
      .enable  (drive_r),
      .dead_en (dead_r),
      .gate_n  (pair[0]),
      .gate_p  (pair[1])
    );
    if (g < 2) begin : g_l
      assign gate_left[2*g +: 2] = pair;
    end else begin : g_r
      assign gate_right[2*(g-2) +: 2] = pair;
    end
  end

  assign left_gain_code      = ctrl_r[acw_pkg::LEFT_LSB +: 9]; // R16
  assign right_gain_code     = ctrl_r[acw_pkg::RIGHT_LSB +: 9]; // R16
  assign low_tone_direction  = ctrl_r[acw_pkg::LOW_DIR_BIT]; // R18
  assign low_tone_gain       = ctrl_r[acw_pkg::LOW_GAIN_LSB +: 4]; // R19
  assign low_tone_corner     = ctrl_r[acw_pkg::LOW_CORNER_LSB +: 2]; // R20
  assign high_tone_direction = ctrl_r[acw_pkg::HIGH_DIR_BIT]; // R21
  assign high_tone_gain      = ctrl_r[acw_pkg::HIGH_GAIN_LSB +: 4]; // R22
  assign high_tone_corner    = ctrl_r[acw_pkg::HIGH_CORNER_LSB +: 2]; // R23
  assign low_corner_valid    = low_tone_corner != 2'h3; // R24
  assign high_corner_valid   = high_tone_corner != 2'h3; // R24
  assign dead_time_on        = dead_r;
  assign drive_enabled       = drive_r;

  a_mute_off : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sync_mute_r[1] |=> !drive_r) else $error("drive on during mute"); // R1
  a_hold_gate : assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(drive_r) |-> hold_r == MUTE_HOLD) else $error("hold too short"); // R2
  a_gates_quiet : assert property (@(posedge sys_clk) disable iff (!rst_n)
    !drive_r |=> gate_left == 4'h0 && gate_right == 4'h0) else $error("gate on muted"); // R1
  a_mode_pick : assert property (@(posedge sys_clk) disable iff (!rst_n)
    sync_sa_r[1] && !sync_sb_r[1] |=> dead_r) else $error("mode not taken"); // R4
  a_short_drop : assert property (@(posedge sys_clk) disable iff (!rst_n)
    en_n && cnt_r != 7'(acw_pkg::WORD_BITS) |=> $stable(ctrl_r)) else $error("short word"); // R11
  a_read_turn : assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(out_en_r) |-> $past(ck_fall) && st_r == acw_pkg::ACW_READ)
    else $error("bad turnaround"); // R12
  a_no_drive_wr : assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r == acw_pkg::ACW_SHIFT |-> serial_data_line_oe_n) else $error("drove on write"); // R12
  a_vol_field : assert property (@(posedge sys_clk) disable iff (!rst_n)
    left_gain_code == ctrl_r[8:0] && right_gain_code == ctrl_r[17:9])
    else $error("volume map"); // R16

  // a word ends cleanly only with enable high after exactly 72 clocks
  sequence s_word_end;
    en_n && st_r == acw_pkg::ACW_SHIFT && cnt_r == 7'(acw_pkg::WORD_BITS);
  endsequence

  sequence s_write_pre;
    pre_r == {acw_pkg::CHIP_ADDR, acw_pkg::SILICON_REF, acw_pkg::DIR_WRITE};
  endsequence

  a_write_commit : assert property (@(posedge sys_clk) disable iff (!rst_n) // R11 R15
    s_word_end ##0 s_write_pre |=> ctrl_r == $past(shift_r))
    else $error("write not committed");

  a_long_word : assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    st_r == acw_pkg::ACW_SHIFT && !en_n && ck_rise && cnt_r == 7'(acw_pkg::WORD_BITS)
    |=> st_r == acw_pkg::ACW_BAD) else $error("long word kept");

  a_bad_frozen : assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    st_r == acw_pkg::ACW_BAD |=> $stable(ctrl_r)) else $error("bad word written");

  a_idle_count : assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    st_r == acw_pkg::ACW_IDLE |=> cnt_r == 7'h00) else $error("count not cleared");

  // the pin is only ever driven inside a read word
  a_read_idle : assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    st_r != acw_pkg::ACW_READ |=> serial_data_line_oe_n) else $error("drove outside read");

  a_first_bit : assert property (@(posedge sys_clk) disable iff (!rst_n) // R12 R15
    $rose(out_en_r) |-> serial_data_line_o == ctrl_r[63]) else $error("first bit wrong");

  a_reset_vol : assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
    $rose(rst_n) |-> left_gain_code == acw_pkg::VOL_RESET &&
                     right_gain_code == acw_pkg::VOL_RESET) else $error("volume default");

  a_hold_step : assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
    sync_mute_r[1] && hold_r < MUTE_HOLD |=> hold_r == $past(hold_r) + 32'h1 && !drive_r)
    else $error("hold not counting");

  a_no_dead_pick : assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
    !(sync_sa_r[1] && !sync_sb_r[1]) |=> !dead_r) else $error("dead time not allowed");

  // without dead time and with drive enabled both gates of a pair sit opposite
  a_plain_pair : assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
    !dead_r && drive_r |=> gate_left[0] != gate_left[1] && gate_right[0] != gate_right[1])
    else $error("pair not opposite");

  // gap length is fixed at two system cycles, a trade for not sampling the master clock
  a_dead_gap : assert property (@(posedge sys_clk) disable iff (!rst_n) // R6 R7
    dead_r && drive_r && $changed(pwm_left[0]) |=> gate_left[1:0] == 2'h0
    ##1 gate_left[1:0] == 2'h0) else $error("gap missing");
endmodule

// ==== acw_host_model.sv ====
// host-side model of the three-wire serial control link
`timescale 1ns/100ps
module acw_host_model (
  output logic      en_n,
  output logic      sck,
  output logic      sdo,
  input  wire logic line
);
  initial begin
    en_n = 1'b1;
    sck  = 1'b0;
    sdo  = 1'b1;
  end
  // serial clock stands still low between words; data changes only after a fall
  task automatic xfer(input logic [71:0] word, input int nbits, output logic [63:0] rd);
    int i;
    rd   = 64'h0;
    en_n = 1'b0;
    for (i = 0; i < nbits; i++) begin
      sdo = (i < 72) ? word[71-i] : ~sdo;
      #200 sck = 1'b1;
      if (i >= 8 && i < 72) rd = {rd[62:0], line};
      #200 sck = 1'b0;
    end
    // released line shows the inverse so a stale bit cannot pass for data
    sdo = ~sdo;
    #100 en_n = 1'b1;
    #600;
  endtask
endmodule

// ==== tb_amp_control_word_and_drive_mode.sv ====
// self-checking bench for the control word and gate-drive core
`timescale 1ns/100ps
module tb_amp_control_word_and_drive_mode;
  localparam int unsigned HOLD = 20;
  localparam logic [7:0]  WR   = {acw_pkg::CHIP_ADDR, acw_pkg::SILICON_REF, acw_pkg::DIR_WRITE};
  localparam logic [7:0]  RD   = {acw_pkg::CHIP_ADDR, acw_pkg::SILICON_REF, acw_pkg::DIR_READ};
  logic        sys_clk, arst_n, mclk, mute_n, sel_a, sel_b;
  logic [1:0]  pwm_l, pwm_r, lcor, hcor;
  logic        en_n, sck, sdo, dev_o, dev_oe_n, line;
  logic [3:0]  gl, gr, lgain, hgain;
  logic [8:0]  lgc, rgc;
  logic        ldir, hdir, lval, hval, dt_on, drv_en;
  logic [63:0] reg_exp, rd, wd;
  int          bad_count, checks_done, seed, i, j;
  assign line = dev_oe_n ? sdo : dev_o;
  acw_core #(.MUTE_HOLD(HOLD)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .master_clock_pin(mclk),
    .serial_enable_n(en_n), .serial_clock_line(sck), .serial_data_line_i(line),
    .serial_data_line_o(dev_o), .serial_data_line_oe_n(dev_oe_n), .mute_n(mute_n),
    .drive_select_a(sel_a), .drive_select_b(sel_b), .pwm_left(pwm_l), .pwm_right(pwm_r),
    .gate_left(gl), .gate_right(gr), .left_gain_code(lgc), .right_gain_code(rgc),
    .low_tone_direction(ldir), .low_tone_gain(lgain), .low_tone_corner(lcor),
    .high_tone_direction(hdir), .high_tone_gain(hgain), .high_tone_corner(hcor),
    .low_corner_valid(lval), .high_corner_valid(hval), .dead_time_on(dt_on),
    .drive_enabled(drv_en));
  acw_host_model host (.en_n(en_n), .sck(sck), .sdo(sdo), .line(line));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    mclk = 1'b0;
    forever #15 mclk = ~mclk;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [63:0] fields();
    return {32'h0, hcor, hgain, hdir, lcor, lgain, ldir, rgc, lgc};
  endfunction
  function automatic logic [63:0] valid_exp(input logic [63:0] d);
    return {62'h0, d[24:23] != 2'b11, d[31:30] != 2'b11};
  endfunction
  task automatic check_reg();
    chk(fields(), {32'h0, reg_exp[31:0]});
    chk({62'h0, lval, hval}, valid_exp(reg_exp));
  endtask
  task automatic drive_step(input logic dead);
    int gap, k;
    gap = 0;
    @(negedge sys_clk);
    pwm_l = ~pwm_l;
    pwm_r = 2'($random(seed));
    for (k = 0; k < 8; k++) begin
      @(negedge sys_clk);
      if (gl[0] === 1'b0 && gl[1] === 1'b0) gap++;
      chk({63'h0, gl[0] & gl[1]}, 64'h0);
      if (!dead) chk({63'h0, gl[0] ^ gl[1]}, 64'h1);
    end
    if (dead) chk({63'h0, gap >= 1 && gap <= 2}, 64'h1);
    chk({56'h0, gr, gl}, {56'h0, ~pwm_r[1], pwm_r[1], ~pwm_r[0], pwm_r[0],
        ~pwm_l[1], pwm_l[1], ~pwm_l[0], pwm_l[0]});
  endtask
  task automatic report_and_stop;
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #3000000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    seed = 83;
    bad_count = 0;
    checks_done = 0;
    arst_n = 1'b0;
    mute_n = 1'b1;
    sel_a = 1'b0;
    sel_b = 1'b0;
    pwm_l = 2'h0;
    pwm_r = 2'h0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) arst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    reg_exp = {46'h0, 9'h0FA, 9'h0FA};
    check_reg();
    chk({55'h0, dev_oe_n, gr, gl}, 64'h100);
    host.xfer({RD, 64'h0}, 72, rd);
    chk(rd, reg_exp);
    for (i = 0; i < 8; i++) begin
      wd = {$random(seed), $random(seed)};
      if (i == 0) wd[31:23] = {2'b11, wd[29:25], 2'b11};
      if (i == 1) wd[17:0] = {9'h130, 9'h041};
      host.xfer({WR, wd}, 72, rd);
      reg_exp = wd;
      check_reg();
      if (i % 2 == 0) host.xfer({RD, ~wd}, 72, rd);
      if (i % 2 == 0) chk(rd, reg_exp);
    end
    // dropped words: wrong length, address set, wrong reference code
    for (i = 0; i < 4; i++) begin
      host.xfer({(i < 2) ? WR : ((i == 2) ? {2'b01, acw_pkg::SILICON_REF, acw_pkg::DIR_WRITE}
                                          : 8'h0A), ~reg_exp},
                (i == 0) ? 71 : ((i == 1) ? 73 : 72), rd);
      check_reg();
    end
    @(negedge sys_clk) mute_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({55'h0, drv_en, gr, gl}, 64'h0);
    mute_n = 1'b1;
    for (i = 0; i < HOLD - 2; i++) begin
      @(negedge sys_clk);
      chk({63'h0, drv_en}, 64'h0);
    end
    for (i = 0; i < 40 && drv_en !== 1'b1; i++) @(negedge sys_clk);
    chk({63'h0, drv_en}, 64'h1);
    for (i = 0; i < 4; i++) begin
      sel_a = i[0];
      sel_b = i[1];
      repeat (4) @(negedge sys_clk);
      chk({63'h0, dt_on}, {63'h0, i == 1});
      for (j = 0; j < 4; j++) drive_step(i == 1);
    end
    mute_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({56'h0, gr, gl}, 64'h0);
    report_and_stop();
  end
endmodule
